//--- hw/ectr_pkg.sv
package ectr_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_NS    = 40;
  localparam int TICK_NS          = 1000000;
  localparam int TICK_CYCLES      = TICK_NS / CLK_PERIOD_NS;
  // Holdover delays, ms
  localparam int HOLD_200_MS      = 200;
  localparam int HOLD_100_MS      = 100;
  localparam int HOLD_150_MS      = 150;
  // Double-talk ramp times, ms, and widest swing in dB
  localparam int DT_ATTACK_MS     = 40;
  localparam int DT_DECAY_SLOW_MS = 1000;
  localparam int DT_DECAY_FAST_MS = 100;
  localparam int DT_MAX_DB        = 21;
  localparam int DT_ATTACK_STEP   = (DT_ATTACK_MS / DT_MAX_DB < 1) ? 1 : DT_ATTACK_MS / DT_MAX_DB;
  localparam int DT_SLOW_STEP     = DT_DECAY_SLOW_MS / DT_MAX_DB;
  localparam int DT_FAST_STEP     = DT_DECAY_FAST_MS / DT_MAX_DB;
  // Noise estimator rise: ms per dB for 3, 6 and 12 dB/s
  localparam int NSE_MS_PER_S     = 1000;
  localparam int NSE_STEP_3       = NSE_MS_PER_S / 3;
  localparam int NSE_STEP_6       = NSE_MS_PER_S / 6;
  localparam int NSE_STEP_12      = NSE_MS_PER_S / 12;
  // Retrain time after howl or path change, ms
  localparam int RETRAIN_MS       = 500;
  // Transmit speech detector threshold, dB
  localparam logic [7:0] TX_DETECT_DB = 8'h06;
  // Register byte offsets
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_HDDT   = 8'h04;
  localparam logic [7:0] OFS_SUPP   = 8'h08;
  localparam logic [7:0] OFS_DUPLEX = 8'h0C;
  localparam logic [7:0] OFS_DETDIS = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // Identity codes in bits 3-0 of each control word
  localparam logic [3:0] ID_HDDT    = 4'h4;
  localparam logic [3:0] ID_SUPP    = 4'h6;
  localparam logic [3:0] ID_DUPLEX  = 4'h8;
  localparam logic [3:0] ID_DETDIS  = 4'hA;
  // Reset values
  localparam logic [15:0] RST_HDDT   = 16'h0004;
  localparam logic [15:0] RST_SUPP   = 16'h0006;
  localparam logic [15:0] RST_DUPLEX = 16'h0008;
  localparam logic [15:0] RST_DETDIS = 16'h000A;
  // Field positions (low bit of each field)
  localparam int F_RX_DET = 14;
  localparam int F_RX_SUP = 12;
  localparam int F_NSE    = 10;
  localparam int F_HOLD   = 8;
  localparam int F_HOWL   = 7;
  localparam int F_TXDEC  = 6;
  localparam int F_RXDEC  = 5;
  localparam int F_IDLE_AUTO_TRANSMIT  = 4;
  localparam int F_TX_SUPPRESS_ATTENUATION  = 14;
  localparam int F_PATH_CHANGE_SENSITIVITY  = 13;
  localparam int F_TXDT   = 10;
  localparam int F_RXDT   = 8;
  localparam int F_TX_SUPPRESS_ERLE_THRESHOLD  = 6;
  localparam int F_TX_SUPPRESS_BIAS = 4;
  localparam int F_ACOUSTIC_ERLE_THRESHOLD  = 14;
  localparam int F_ANSE   = 12;
  localparam int F_NETWORK_ERLE_THRESHOLD  = 10;
  localparam int F_NNSE   = 8;
  localparam int F_RX_ANALOG_GAIN  = 6;
  localparam int F_TX_ANALOG_GAIN  = 4;
  // Half-duplex engine states
  typedef enum logic [3:0] {
    ECTR_IDLE = 4'b0001,
    ECTR_TX   = 4'b0010,
    ECTR_RX   = 4'b0100,
    ECTR_HOLD = 4'b1000
  } ectr_hd_e;
endpackage

//--- hw/ectr_tuning.sv
////////////////////////////////////////////////////////////////////////////////
module ectr_noise_est
  import ectr_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Time base and rate
  input  wire logic       tick,
  input  wire logic [1:0] rate,
  // Power in, estimate out
  input  wire logic [7:0] power,
  output logic      [7:0] estimate
);
  logic [9:0] step_ms;
  logic [9:0] count;

  // Milliseconds per dB of rise; reserved code runs at the slowest rate
  always_comb begin
    case (rate)
      2'b01:   step_ms = 10'(NSE_STEP_6);
      2'b10:   step_ms = 10'(NSE_STEP_12);
      default: step_ms = 10'(NSE_STEP_3);
    endcase
  end

  // Slow rise, instant fall
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      estimate <= 8'h00;
      count    <= 10'h000;
    end else if (power < estimate) begin
      estimate <= power;
      count    <= 10'h000;
    end else if (power > estimate && tick) begin
      if (count + 10'h001 >= step_ms) begin
        estimate <= estimate + 8'h01;
        count    <= 10'h000;
      end else begin
        count <= count + 10'h001;
      end
    end
  end
endmodule
////////////////////////////////////////////////////////////////////////////////
module ectr_dt_ramp
  import ectr_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Time base, goal and decay choice
  input  wire logic       tick,
  input  wire logic [4:0] target,
  input  wire logic       decay_fast,
  // Current attenuation, dB
  output logic      [4:0] level
);
  logic [6:0] step_ms;
  logic [6:0] count;

  // Attack is fixed, decay follows the rate bit
  always_comb begin
    if (target > level) begin
      step_ms = 7'(DT_ATTACK_STEP);
    end else if (decay_fast) begin
      step_ms = 7'(DT_FAST_STEP);
    end else begin
      step_ms = 7'(DT_SLOW_STEP);
    end
  end

  // One dB per step toward the goal
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      level <= 5'h00;
      count <= 7'h00;
    end else if (target == level) begin
      count <= 7'h00;
    end else if (tick) begin
      if (count + 7'h01 >= step_ms) begin
        count <= 7'h00;
        level <= (target > level) ? level + 5'h01 : level - 5'h01;
      end else begin
        count <= count + 7'h01;
      end
    end
  end
endmodule
////////////////////////////////////////////////////////////////////////////////
module ectr_tuning
  import ectr_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
)(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Measurements from the echo datapath, dB
  input  wire logic [7:0]  rx_power,
  input  wire logic [7:0]  tx_power,
  input  wire logic [7:0]  near_noise_atten,
  input  wire logic [7:0]  far_noise_atten,
  input  wire logic [7:0]  aec_erle,
  input  wire logic [7:0]  nec_erle,
  input  wire logic        aec_asym_ok,
  input  wire logic        nec_asym_ok,
  input  wire logic        net_path_present,
  input  wire logic        howl_event,
  input  wire logic        path_change_event,
  // Controls to the datapath
  output ectr_hd_e         hd_state,
  output logic             full_duplex,
  output logic             nec_enable,
  output logic             rx_suppress_on,
  output logic [7:0]       tx_suppress_db,
  output logic [7:0]       tx_suppress_erle_db,
  output logic [7:0]       tx_suppress_bias_db,
  output logic [4:0]       tx_doubletalk_db,
  output logic [4:0]       rx_doubletalk_db,
  output logic [4:0]       rx_gain_half_db,
  output logic [4:0]       tx_gain_half_db,
  output logic [15:0]      detector_disable_word
);
  logic [15:0] halfduplex_doubletalk_ctrl;
  logic [15:0] suppression_tuning_ctrl;
  logic [15:0] duplex_threshold_gain_ctrl;
  logic [15:0] detector_disable_ctrl;
  logic [14:0] tick_count;
  logic        tick;
  logic [7:0]  rx_noise;
  logic [7:0]  tx_noise;
  logic [7:0]  rx_detect_db;
  logic [7:0]  rx_supp_db;
  logic        rx_speech;
  logic        tx_speech;
  logic        rx_supp_clear;
  logic        rx_supp_state;
  ectr_hd_e    state;
  ectr_hd_e    next_state;
  ectr_hd_e    owner;
  logic [7:0]  hold_ms;
  logic [7:0]  hold_count;
  logic        howl_latch;
  logic [9:0]  retrain_count;
  logic        aec_ok;
  logic        nec_ok;
  logic [7:0]  acoustic_erle_threshold_db;
  logic [7:0]  network_erle_threshold_db;
  logic [7:0]  anse_db;
  logic [7:0]  nnse_db;
  logic [4:0]  tx_dt_target;
  logic [4:0]  rx_dt_target;
  logic [4:0]  tx_dt_level;
  logic [4:0]  rx_dt_level;
  logic        apb_write;
  logic        apb_read;
  logic [3:0]  word_id;

  // Decoded dB tables
  function automatic logic [7:0] thr_6_9_12(input logic [1:0] code);
    case (code)
      2'b01:   thr_6_9_12 = 8'h09;
      2'b10:   thr_6_9_12 = 8'h0C;
      default: thr_6_9_12 = 8'h06;
    endcase
  endfunction

  function automatic logic [7:0] erle_db(input logic [1:0] code);
    case (code)
      2'b01:   erle_db = 8'h12;
      2'b10:   erle_db = 8'h1E;
      default: erle_db = 8'h18;
    endcase
  endfunction

  function automatic logic [7:0] noise_db(input logic [1:0] code);
    case (code)
      2'b01:   noise_db = 8'h2A;
      2'b10:   noise_db = 8'h36;
      default: noise_db = 8'h00;
    endcase
  endfunction

  function automatic logic [4:0] gain_half_db(input logic [1:0] code);
    case (code)
      2'b01:   gain_half_db = 5'h0C;
      2'b10:   gain_half_db = 5'h13;
      2'b11:   gain_half_db = 5'h18;
      default: gain_half_db = 5'h00;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait-free access phase, answer registered
  assign apb_write = psel && penable && pready && pwrite;
  assign apb_read  = psel && !penable && !pwrite;
  assign word_id   = pwdata[3:0];

  // Ready rises in the setup cycle so the access phase completes at once
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        if (pwrite) begin
          // Command writes with an unknown code are refused
          pslverr <= (paddr != OFS_CMD) || !(word_id == ID_HDDT || word_id == ID_SUPP ||
                     word_id == ID_DUPLEX || word_id == ID_DETDIS);
        end else begin
          case (paddr)
            OFS_CMD:    prdata <= 32'h0000_0000;
            OFS_HDDT:   prdata <= {16'h0000, halfduplex_doubletalk_ctrl};
            OFS_SUPP:   prdata <= {16'h0000, suppression_tuning_ctrl};
            OFS_DUPLEX: prdata <= {16'h0000, duplex_threshold_gain_ctrl};
            OFS_DETDIS: prdata <= {16'h0000, detector_disable_ctrl};
            OFS_STATUS: prdata <= {21'h000000, rx_supp_state, nec_enable, tx_speech, rx_speech,
                                   (retrain_count != 10'h000), howl_latch, full_duplex, state};
            default: begin
              prdata  <= 32'h0000_0000;
              pslverr <= apb_read;
            end
          endcase
        end
      end
    end
  end

  // Words land by their identity code, not by address
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      halfduplex_doubletalk_ctrl <= RST_HDDT;
      suppression_tuning_ctrl    <= RST_SUPP;
      duplex_threshold_gain_ctrl <= RST_DUPLEX;
      detector_disable_ctrl      <= RST_DETDIS;
    end else if (apb_write && !pslverr) begin
      case (word_id)
        ID_HDDT:   halfduplex_doubletalk_ctrl <= pwdata[15:0];
        ID_SUPP:   suppression_tuning_ctrl    <= pwdata[15:0];
        ID_DUPLEX: duplex_threshold_gain_ctrl <= pwdata[15:0];
        ID_DETDIS: detector_disable_ctrl      <= pwdata[15:0];
        default:   ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Millisecond tick; all engine times count in ticks to keep counters small
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tick_count <= 15'h0000;
      tick       <= 1'b0;
    end else begin
      tick       <= (tick_count == 15'(TICK_LEN - 1));
      tick_count <= (tick_count == 15'(TICK_LEN - 1)) ? 15'h0000 : tick_count + 15'h0001;
    end
  end

  // Noise floors for both channels
  ectr_noise_est u_rx_noise (
    .clock    (clock),
    .nrst     (nrst),
    .tick     (tick),
    .rate     (halfduplex_doubletalk_ctrl[F_NSE +: 2]),
    .power    (rx_power),
    .estimate (rx_noise)
  );
  ectr_noise_est u_tx_noise (
    .clock    (clock),
    .nrst     (nrst),
    .tick     (tick),
    .rate     (halfduplex_doubletalk_ctrl[F_NSE +: 2]),
    .power    (tx_power),
    .estimate (tx_noise)
  );

  // Speech detectors; nine-bit sums so a high floor cannot wrap
  assign rx_detect_db  = thr_6_9_12(halfduplex_doubletalk_ctrl[F_RX_DET +: 2]);
  assign rx_supp_db    = thr_6_9_12(halfduplex_doubletalk_ctrl[F_RX_SUP +: 2]);
  assign rx_speech     = {1'b0, rx_power} >= {1'b0, rx_noise} + {1'b0, rx_detect_db};
  assign tx_speech     = {1'b0, tx_power} >= {1'b0, tx_noise} + {1'b0, TX_DETECT_DB};
  assign rx_supp_clear = {1'b0, rx_power} >= {1'b0, rx_noise} + {1'b0, rx_supp_db};

  // Receive suppression: removed on strong far end, back when speech ends
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rx_supp_state <= 1'b1;
    end else if (rx_supp_clear) begin
      rx_supp_state <= 1'b0;
    end else if (!rx_speech) begin
      rx_supp_state <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Holdover length in ms
  always_comb begin
    case (halfduplex_doubletalk_ctrl[F_HOLD +: 2])
      2'b01:   hold_ms = 8'(HOLD_100_MS);
      2'b10:   hold_ms = 8'(HOLD_150_MS);
      default: hold_ms = 8'(HOLD_200_MS);
    endcase
  end

  // Half-duplex engine next state
  always_comb begin
    next_state = state;
    case (state)
      ECTR_IDLE: begin
        if (rx_speech) begin
          next_state = ECTR_RX;
        end else if (tx_speech || halfduplex_doubletalk_ctrl[F_IDLE_AUTO_TRANSMIT]) begin
          next_state = ECTR_TX;
        end
      end
      ECTR_TX: begin
        if (!tx_speech) begin
          next_state = ECTR_HOLD;
        end
      end
      ECTR_RX: begin
        if (!rx_speech) begin
          next_state = ECTR_HOLD;
        end
      end
      ECTR_HOLD: begin
        // Only the old owner may resume; the other side waits out echoes
        if ((owner == ECTR_TX && tx_speech) || (owner == ECTR_RX && rx_speech)) begin
          next_state = owner;
        end else if (tick && hold_count + 8'h01 >= hold_ms) begin
          next_state = ECTR_IDLE;
        end
      end
      default: next_state = ECTR_IDLE;
    endcase
  end

  // State, owner and holdover timer
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state      <= ECTR_IDLE;
      owner      <= ECTR_IDLE;
      hold_count <= 8'h00;
    end else begin
      state <= next_state;
      if (next_state == ECTR_TX || next_state == ECTR_RX) begin
        owner <= next_state;
      end
      if (state != ECTR_HOLD) begin
        hold_count <= 8'h00;
      end else if (tick) begin
        hold_count <= hold_count + 8'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Howl hold and retrain window; a howl, or a path change while the sensitivity bit is clear, restarts the window
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      howl_latch    <= 1'b0;
      retrain_count <= 10'h000;
    end else begin
      if (!halfduplex_doubletalk_ctrl[F_HOWL]) begin
        howl_latch <= 1'b0;
      end else if (howl_event) begin
        howl_latch <= 1'b1;
      end
      if (howl_event || (path_change_event && !suppression_tuning_ctrl[F_PATH_CHANGE_SENSITIVITY])) begin
        retrain_count <= 10'(RETRAIN_MS);
      end else if (tick && retrain_count != 10'h000) begin
        retrain_count <= retrain_count - 10'h001;
      end
    end
  end

  // Full-duplex admission per canceller
  assign acoustic_erle_threshold_db = erle_db(duplex_threshold_gain_ctrl[F_ACOUSTIC_ERLE_THRESHOLD +: 2]);
  assign network_erle_threshold_db = erle_db(duplex_threshold_gain_ctrl[F_NETWORK_ERLE_THRESHOLD +: 2]);
  assign anse_db  = noise_db(duplex_threshold_gain_ctrl[F_ANSE +: 2]);
  assign nnse_db  = noise_db(duplex_threshold_gain_ctrl[F_NNSE +: 2]);
  // Noise attenuation below the threshold magnitude means noise above it
  assign aec_ok = (anse_db == 8'h00 || near_noise_atten < anse_db) ?
                  (aec_erle > acoustic_erle_threshold_db) : aec_asym_ok;
  assign nec_ok = !nec_enable ||
                  ((nnse_db == 8'h00 || far_noise_atten < nnse_db) ?
                   (nec_erle > network_erle_threshold_db) : nec_asym_ok);

  // Double-talk goals from attenuation codes
  assign tx_dt_target = (tx_speech && rx_speech) ?
                        5'(3 * suppression_tuning_ctrl[F_TXDT +: 3]) : 5'h00;
  assign rx_dt_target = (tx_speech && rx_speech) ?
                        5'(3 * suppression_tuning_ctrl[F_RXDT +: 2]) : 5'h00;

  ectr_dt_ramp u_tx_dt (
    .clock      (clock),
    .nrst       (nrst),
    .tick       (tick),
    .target     (tx_dt_target),
    .decay_fast (halfduplex_doubletalk_ctrl[F_TXDEC]),
    .level      (tx_dt_level)
  );
  ectr_dt_ramp u_rx_dt (
    .clock      (clock),
    .nrst       (nrst),
    .tick       (tick),
    .target     (rx_dt_target),
    .decay_fast (halfduplex_doubletalk_ctrl[F_RXDEC]),
    .level      (rx_dt_level)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Registered controls to the datapath
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hd_state              <= ECTR_IDLE;
      full_duplex           <= 1'b0;
      nec_enable            <= 1'b1;
      rx_suppress_on        <= 1'b1;
      tx_suppress_db        <= 8'h00;
      tx_suppress_erle_db   <= 8'h0F;
      tx_suppress_bias_db   <= 8'h12;
      tx_doubletalk_db      <= 5'h00;
      rx_doubletalk_db      <= 5'h00;
      rx_gain_half_db       <= 5'h00;
      tx_gain_half_db       <= 5'h00;
      detector_disable_word <= RST_DETDIS;
    end else begin
      hd_state       <= state;
      full_duplex    <= aec_ok && nec_ok && !howl_latch && (retrain_count == 10'h000);
      nec_enable     <= !(nnse_db != 8'h00 && !net_path_present);
      rx_suppress_on <= rx_supp_state;
      // Engaged whenever the near end is silent; reserved code gives 18 dB
      case (suppression_tuning_ctrl[F_TX_SUPPRESS_ATTENUATION +: 2])
        2'b01:   tx_suppress_db <= tx_speech ? 8'h00 : 8'h0C;
        2'b10:   tx_suppress_db <= tx_speech ? 8'h00 : 8'h18;
        default: tx_suppress_db <= tx_speech ? 8'h00 : 8'h12;
      endcase
      case (suppression_tuning_ctrl[F_TX_SUPPRESS_ERLE_THRESHOLD +: 2])
        2'b01:   tx_suppress_erle_db <= 8'h0C;
        2'b10:   tx_suppress_erle_db <= 8'h09;
        2'b11:   tx_suppress_erle_db <= 8'h12;
        default: tx_suppress_erle_db <= 8'h0F;
      endcase
      case (suppression_tuning_ctrl[F_TX_SUPPRESS_BIAS +: 2])
        2'b01:   tx_suppress_bias_db <= 8'h0F;
        2'b10:   tx_suppress_bias_db <= 8'h15;
        default: tx_suppress_bias_db <= 8'h12;
      endcase
      tx_doubletalk_db      <= tx_dt_level;
      rx_doubletalk_db      <= rx_dt_level;
      rx_gain_half_db       <= gain_half_db(duplex_threshold_gain_ctrl[F_RX_ANALOG_GAIN +: 2]);
      tx_gain_half_db       <= gain_half_db(duplex_threshold_gain_ctrl[F_TX_ANALOG_GAIN +: 2]);
      detector_disable_word <= detector_disable_ctrl;
    end
  end
endmodule

//--- bench/ectr_tuning_properties.sv
module ectr_tuning_properties
  import ectr_pkg::*;
(
  // Clock, reset and bus
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Engine and decoded fields
  input wire logic        howl_event,
  input wire ectr_hd_e    hd_state,
  input wire logic        full_duplex,
  input wire logic [7:0]  tx_suppress_db,
  input wire logic [7:0]  tx_suppress_erle_db,
  input wire logic [7:0]  tx_suppress_bias_db,
  input wire logic [4:0]  tx_doubletalk_db,
  input wire logic [4:0]  rx_gain_half_db
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  // Writes with a bad identity are refused
  property p_refuse;
    psel && penable && pwrite && pready && !(pwdata[3:0] inside {4'h4, 4'h6, 4'h8, 4'hA}) |-> pslverr;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad identity accepted");
  property p_erle;
    tx_suppress_erle_db inside {8'd15, 8'd12, 8'd9, 8'd18};
  endproperty
  a_erle: assert property (p_erle) else $error("erle threshold off table");
  property p_bias;
    tx_suppress_bias_db inside {8'd18, 8'd15, 8'd21};
  endproperty
  a_bias: assert property (p_bias) else $error("bias off table");
  property p_supp;
    tx_suppress_db inside {8'd0, 8'd12, 8'd18, 8'd24};
  endproperty
  a_supp: assert property (p_supp) else $error("tx suppression off table");
  // Ramp moves one dB at a time, never jumps
  property p_txdt;
    !$stable(tx_doubletalk_db) |-> 5'(tx_doubletalk_db - $past(tx_doubletalk_db)) inside {5'h01, 5'h1F};
  endproperty
  a_txdt: assert property (p_txdt) else $error("double-talk ramp jumped");
  property p_gain;
    rx_gain_half_db inside {5'd0, 5'd12, 5'd19, 5'd24};
  endproperty
  a_gain: assert property (p_gain) else $error("gain off table");
  property p_howl;
    howl_event |-> ##[1:3] !full_duplex [*8];
  endproperty
  a_howl: assert property (p_howl) else $error("full duplex kept after howl");
  // Idle only ever follows holdover
  property p_idle;
    hd_state == ECTR_IDLE && $past(hd_state) != ECTR_IDLE |-> $past(hd_state) == ECTR_HOLD;
  endproperty
  a_idle: assert property (p_idle) else $error("idle without holdover");
  c_howl: cover property (howl_event);
  c_tx: cover property (hd_state == ECTR_TX);
  c_err: cover property (pready && pslverr);
endmodule

bind ectr_tuning ectr_tuning_properties chk_inst (.*);

//--- bench/ectr_host.sv
module ectr_host
(
  // Clock
  input wire logic        clock,
  // APB master side
  output logic            psel = 0,
  output logic            penable = 0,
  output logic            pwrite = 0,
  output logic [7:0]      paddr = 0,
  output logic [31:0]     pwdata = 0,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  int lost = 0;
  ////////////////////////////////////////
  // One whole transfer; held until pready
  task automatic xfer(logic w, logic [7:0] a, logic [15:0] d, output logic [15:0] q, output logic e);
    int n;
    @(posedge clock);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge clock);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (!pready && n < 50);
    if (!pready) lost++; // Bound used up, counted as a mismatch
    q = prdata[15:0];
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
endmodule

//--- bench/ectr_tuning_tb.sv
module ectr_tuning_tb
  import ectr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, nrst = 0, psel, penable, pwrite, pready, pslverr, full_duplex, nec_enable, rx_suppress_on;
  logic aec_asym_ok = 1, nec_asym_ok = 1, net_path_present = 1, howl_event = 0, path_change_event = 0;
  logic [7:0] paddr, tx_suppress_db, tx_suppress_erle_db, tx_suppress_bias_db, rx_power = 0, tx_power = 0;
  logic [7:0] near_noise_atten = 8'h3C, far_noise_atten = 8'h3C, aec_erle = 8'h3C, nec_erle = 8'h3C;
  logic [31:0] pwdata, prdata;
  logic [4:0] tx_doubletalk_db, rx_doubletalk_db, rx_gain_half_db, tx_gain_half_db;
  logic [15:0] detector_disable_word, w;
  ectr_hd_e hd_state;
  logic [17:0] exp_q[$];
  logic [17:0] e;
  int fails = 0, checked = 0;
  // Decode tables
  logic [15:0] RV[4] = '{16'h0004, 16'h0006, 16'h0008, 16'h000A};
  logic [7:0] ATT[3] = '{8'd18, 8'd12, 8'd24}, BIAS[3] = '{8'd18, 8'd15, 8'd21};
  logic [7:0] ERLE[4] = '{8'd15, 8'd12, 8'd9, 8'd18}, GAIN[4] = '{8'd0, 8'd12, 8'd19, 8'd24};
  // Short tick keeps the 500 ms retrain near 5000 cycles
  ectr_tuning #(.TICK_LEN(10)) ectr_tuning_inst (.*);
  ectr_host host_inst (.*);
  always #20 clock = ~clock;
  ////////////////////////////////////////
  task automatic results();
    fails += host_inst.lost;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] ex, logic [15:0] g);
    checked++;
    if (g !== ex) begin
      $display("wrong value %s exp %h got %h", n, ex, g);
      fails++;
    end
  endtask
  task automatic op(logic wr, logic [7:0] a, logic [15:0] d, logic er, logic [15:0] ex);
    logic [15:0] q;
    logic x;
    exp_q.push_back({!wr, er, ex});
    host_inst.xfer(wr, a, d, q, x);
    if (host_inst.lost != 0) results();
  endtask
  task automatic waitst(ectr_hd_e s);
    int n = 0;
    while (hd_state !== s && n < 200) begin
      @(posedge clock);
      n++;
    end
    chk("hd_state", 16'(s), 16'(hd_state));
    if (n == 200) results();
  endtask
  // Bus watcher: oldest note against each completed transfer
  always @(posedge clock) begin
    if (psel && penable && pready) begin
      e = exp_q.pop_front();
      checked++;
      if (pslverr !== e[16] || (e[17] && prdata[15:0] !== e[15:0])) begin
        $display("wrong value apb exp %h got %h err %b", e, prdata, pslverr);
        fails++;
      end
    end
  end
  initial begin
    void'($urandom(32'h99FF));
    repeat (12) @(posedge clock);
    nrst <= 1;
    foreach (RV[i]) op(0, 8'(4 * i + 4), 0, 0, RV[i]);
    op(0, 8'h18, 0, 1, 0);
    op(1, 8'h00, 16'h0003, 1, 0);
    op(1, 8'h04, 16'h0008, 1, 0);
    op(0, 8'h0C, 0, 0, 16'h0008);
    $display("test reset and refusal done");
    // Near end silent, so suppression shows the full attenuation
    for (int i = 0; i < 4; i++) begin
      w = 16'(((i % 3) << 14) | (i << 6) | ((i % 3) << 4) | 6);
      op(1, 0, w, 0, 0);
      op(0, 8'h08, 0, 0, w);
      repeat (3) @(posedge clock);
      chk("tx_suppress_db", 16'(ATT[i % 3]), 16'(tx_suppress_db));
      chk("erle", 16'(ERLE[i]), 16'(tx_suppress_erle_db));
      chk("bias", 16'(BIAS[i % 3]), 16'(tx_suppress_bias_db));
      op(1, 0, 16'((i << 6) | (i << 4) | 8), 0, 0);
      repeat (3) @(posedge clock);
      chk("rx_gain", 16'(GAIN[i]), 16'(rx_gain_half_db));
      chk("tx_gain", 16'(GAIN[i]), 16'(tx_gain_half_db));
    end
    $display("test field decode done");
    w = {12'($urandom_range(4095)), 4'hA};
    op(1, 0, w, 0, 0);
    op(0, 8'h10, 0, 0, w);
    repeat (3) @(posedge clock);
    chk("detector_disable_word", w, detector_disable_word);
    // Hold on howl, idle return to transmit, random noise ramp
    op(1, 0, {4'h0, 2'($urandom_range(2)), 2'b01, 8'h94}, 0, 0);
    waitst(ECTR_TX);
    howl_event <= 1;
    @(posedge clock);
    howl_event <= 0;
    repeat (6000) @(posedge clock);
    chk("full_duplex", 0, 16'(full_duplex));
    $display("test howl hold done");
    // Clearing the hold bit lets full duplex back once retrain is over
    op(1, 0, 16'h0144, 0, 0);
    repeat (3) @(posedge clock);
    chk("full_duplex", 1, 16'(full_duplex));
    path_change_event <= 1;
    @(posedge clock);
    path_change_event <= 0;
    repeat (3) @(posedge clock);
    chk("full_duplex", 0, 16'(full_duplex));
    $display("test hold release and path change done");
    // Both ends talk: 21 dB tx and 9 dB rx goals, fast tx and slow rx decay
    op(1, 0, 16'h1F06, 0, 0);
    chk("rx_suppress_on", 1, 16'(rx_suppress_on));
    rx_power <= 8'h40;
    tx_power <= 8'h40;
    repeat (300) @(posedge clock);
    chk("tx_doubletalk_db", 16'd21, 16'(tx_doubletalk_db));
    chk("rx_doubletalk_db", 16'd9, 16'(rx_doubletalk_db));
    chk("rx_suppress_on", 0, 16'(rx_suppress_on));
    chk("tx_suppress_db", 0, 16'(tx_suppress_db));
    tx_power <= 8'h00;
    repeat (1200) @(posedge clock);
    chk("tx_doubletalk_db", 0, 16'(tx_doubletalk_db));
    chk("rx_doubletalk_db busy", 1, 16'(rx_doubletalk_db != 5'h00));
    $display("test double talk done");
    // Nonzero network noise threshold and no network path
    op(1, 0, 16'h0108, 0, 0);
    net_path_present <= 0;
    repeat (3) @(posedge clock);
    chk("nec_enable", 0, 16'(nec_enable));
    $display("test network canceller done");
    results();
  end
endmodule
